// ### rtl/rsg_top.sv
/*
  reset scope and write guard: cold/warm start flag, write protection,
  software reset, clock source after reset, per-source register init.
  assumes hresetn is the power-on reset and reset_req pulses are synchronous.
*/
// Implementation choices: the AHB-Lite interface to the registers and the address map.
// Operation
// - a power-on reset clears the cold/warm start flag to zero.
// - the flag survives all other resets and software may write one to it.
// - the software reset register accepts writes only while protect bit one is set.
// - clock generation registers accept writes only while protect bit zero or one is set.
// - after any reset the low-speed internal oscillator is the clock source and the pll is stopped; all but a deep standby reset stop the others too.
// - of the voltage monitor two registers, a deep standby reset initializes only control one and status.
// - real-time clock control keeps its contents except some bits every reset initializes; here a power-on reset clears all of it.
// - the deep-standby backup registers are never initialized by any reset.
`timescale 1ns/1ps
module rsg_top
  import rsg_pkg::*;
#(
  parameter int BK_DEPTH = BACKUP_DEPTH,
  parameter int BK_WIDTH = BACKUP_WIDTH
) (
  // clock and power-on reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [31:0]          hrdata,
  // reset sources and monitor events
  input  wire logic [NUM_SRC-2:0]   reset_req,
  input  wire logic                 vmon2_detect,
  // clock generation controls
  output logic      [1:0]           clk_src_sel,
  output logic                      high_speed_internal_osc_en,
  output logic                      main_osc_en,
  output logic                      pll_en,
  // reset outputs
  output logic                      sw_reset_req,
  output logic                      system_reset
);

  localparam int AW = $clog2(BK_DEPTH);

  typedef enum logic {RSG_IDLE, RSG_WAIT} rsg_state_t;

  // ==========================================================
  // helpers
  function automatic logic in_scope(input logic [7:0] mask, input logic [7:0] src);
    in_scope = |(mask & src);
  endfunction

  function automatic logic is_backup(input logic [9:0] a);
    is_backup = (a >= OFF_BACKUP_BASE) && (a < OFF_BACKUP_BASE + 10'(BK_DEPTH * 4));
  endfunction

  // ==========================================================
  // state
  rsg_state_t        state, next_state;
  logic [9:0]        addr_q, next_addr_q;
  logic              write_q, next_write_q;
  logic              next_hreadyout;
  logic [31:0]       next_hrdata;
  logic              cold_warm_start_flag, next_cold_warm_start_flag;
  logic              protect_bit_zero, next_protect_bit_zero;
  logic              protect_bit_one, next_protect_bit_one;
  logic [1:0]        next_clk_src_sel;
  logic              next_high_speed_internal_osc_en, next_main_osc_en, next_pll_en;
  logic [7:0]        volt_mon2_control_zero, next_volt_mon2_control_zero;
  logic [7:0]        volt_mon2_control_one, next_volt_mon2_control_one;
  logic [7:0]        volt_mon2_status, next_volt_mon2_status;
  logic [7:0]        rtc_control, next_rtc_control;
  logic [7:0]        reset_source, next_reset_source;
  logic              next_sw_reset_req, next_system_reset;
  logic [7:0]        src;
  logic              accept, wr_now;
  logic [BK_WIDTH-1:0] bk_rdata;

  assign src    = {sw_reset_req, reset_req};
  assign accept = hsel && htrans[1] && hready && hreadyout;
  assign wr_now = (state == RSG_WAIT) && write_q;

  // ==========================================================
  // backup memory
  rsg_backup_mem #(
    .WIDTH (BK_WIDTH),
    .DEPTH (BK_DEPTH),
    .AW    (AW)
  ) u_backup (
    .hclk    (hclk),
    .rd_en   (accept),
    .rd_addr (haddr[AW+1:2]),
    .rd_data (bk_rdata),
    .wr_en   (wr_now && is_backup(addr_q)),
    .wr_addr (addr_q[AW+1:2]),
    .wr_data (hwdata[BK_WIDTH-1:0])
  );

  // ==========================================================
  // bus state and read data
  always_comb
  begin
    next_state     = state;
    next_addr_q    = addr_q;
    next_write_q   = write_q;
    next_hreadyout = hreadyout;
    next_hrdata    = hrdata;
    unique case (state)
      RSG_IDLE:
      begin
        if (accept)
        begin
          next_state     = RSG_WAIT;
          next_addr_q    = haddr[9:0];
          next_write_q   = hwrite;
          next_hreadyout = 1'b0;
        end
      end
      RSG_WAIT:
      begin
        next_state     = RSG_IDLE;
        next_hreadyout = 1'b1;
        next_hrdata    = 32'h0;
        if (!write_q)
        begin
          if (is_backup(addr_q))
          begin
            next_hrdata[BK_WIDTH-1:0] = bk_rdata;
          end
          else
          begin
            unique case (addr_q)
              OFF_RESET_STATUS_ONE:   next_hrdata[BIT_COLD_WARM] = cold_warm_start_flag;
              OFF_WRITE_PROTECT_CTRL: next_hrdata[1:0] = {protect_bit_one, protect_bit_zero};
              OFF_CLOCK_CONTROL:
                next_hrdata[7:0] = {1'b0, pll_en, main_osc_en, high_speed_internal_osc_en, 2'h0, clk_src_sel};
              OFF_VOLT_MON2_CTRL0:    next_hrdata[7:0] = volt_mon2_control_zero;
              OFF_VOLT_MON2_CTRL1:    next_hrdata[7:0] = volt_mon2_control_one;
              OFF_VOLT_MON2_STATUS:   next_hrdata[7:0] = volt_mon2_status;
              OFF_RTC_CONTROL:        next_hrdata[7:0] = rtc_control;
              OFF_RESET_SOURCE:       next_hrdata[7:0] = reset_source;
              default:                next_hrdata = 32'h0;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state     <= RSG_IDLE;
      addr_q    <= 10'h0;
      write_q   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      addr_q    <= next_addr_q;
      write_q   <= next_write_q;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================
  // control registers and reset scopes
  always_comb
  begin
    next_cold_warm_start_flag   = cold_warm_start_flag;
    next_protect_bit_zero       = protect_bit_zero;
    next_protect_bit_one        = protect_bit_one;
    next_clk_src_sel            = clk_src_sel;
    next_high_speed_internal_osc_en                = high_speed_internal_osc_en;
    next_main_osc_en            = main_osc_en;
    next_pll_en                 = pll_en;
    next_volt_mon2_control_zero = volt_mon2_control_zero;
    next_volt_mon2_control_one  = volt_mon2_control_one;
    next_volt_mon2_status       = volt_mon2_status;
    next_rtc_control            = rtc_control;
    next_reset_source           = reset_source;
    next_sw_reset_req           = 1'b0;
    next_system_reset           = |src;
    if (|src)
    begin
      // flag untouched by any source here, only hresetn clears it
      next_reset_source     = src;
      next_protect_bit_zero = RST_PROTECT[0];
      next_protect_bit_one  = RST_PROTECT[1];
      next_clk_src_sel      = CLK_SRC_LOW_SPEED_INTERNAL_OSC;
      next_pll_en           = 1'b0;
      if (in_scope(SCOPE_OSC_ENABLE, src))
      begin
        next_high_speed_internal_osc_en     = 1'b0;
        next_main_osc_en = 1'b0;
      end
      if (in_scope(SCOPE_VMON2_CTRL0, src))
      begin
        next_volt_mon2_control_zero = RST_VOLT_MON2;
      end
      if (in_scope(SCOPE_VMON2_CR1_SR, src))
      begin
        next_volt_mon2_control_one = RST_VOLT_MON2;
        next_volt_mon2_status      = RST_VOLT_MON2;
      end
      next_rtc_control[3:0] = RST_RTC_LOW[3:0];
    end
    else
    begin
      if (wr_now)
      begin
        unique case (addr_q)
          OFF_RESET_STATUS_ONE:
            if (hwdata[BIT_COLD_WARM])
            begin
              next_cold_warm_start_flag = 1'b1;
            end
          OFF_WRITE_PROTECT_CTRL:
          begin
            next_protect_bit_zero = hwdata[BIT_PROTECT_ZERO];
            next_protect_bit_one  = hwdata[BIT_PROTECT_ONE];
          end
          OFF_SOFT_RESET:
            if (protect_bit_one && hwdata[BIT_SOFT_RESET])
            begin
              next_sw_reset_req = 1'b1;
            end
          OFF_CLOCK_CONTROL:
            if (protect_bit_zero || protect_bit_one)
            begin
              next_clk_src_sel = hwdata[1:0];
              next_high_speed_internal_osc_en     = hwdata[BIT_HIGH_SPEED_INTERNAL_OSC_EN];
              next_main_osc_en = hwdata[BIT_MAIN_OSC_EN];
              next_pll_en      = hwdata[BIT_PLL_EN];
            end
          OFF_VOLT_MON2_CTRL0:  next_volt_mon2_control_zero = hwdata[7:0];
          OFF_VOLT_MON2_CTRL1:  next_volt_mon2_control_one  = hwdata[7:0];
          OFF_VOLT_MON2_STATUS: next_volt_mon2_status       = hwdata[7:0];
          OFF_RTC_CONTROL:      next_rtc_control            = hwdata[7:0];
          default:
          begin
          end
        endcase
      end
      // detection set wins over a software clear
      if (vmon2_detect)
      begin
        next_volt_mon2_status[BIT_VMON2_DETECT] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cold_warm_start_flag   <= 1'b0;
      protect_bit_zero       <= RST_PROTECT[0];
      protect_bit_one        <= RST_PROTECT[1];
      clk_src_sel            <= CLK_SRC_LOW_SPEED_INTERNAL_OSC;
      high_speed_internal_osc_en                <= RST_CLOCK_CONTROL[BIT_HIGH_SPEED_INTERNAL_OSC_EN];
      main_osc_en            <= RST_CLOCK_CONTROL[BIT_MAIN_OSC_EN];
      pll_en                 <= RST_CLOCK_CONTROL[BIT_PLL_EN];
      volt_mon2_control_zero <= RST_VOLT_MON2;
      volt_mon2_control_one  <= RST_VOLT_MON2;
      volt_mon2_status       <= RST_VOLT_MON2;
      rtc_control            <= 8'h00;
      reset_source           <= 8'h00;
      sw_reset_req           <= 1'b0;
      system_reset           <= 1'b0;
    end
    else
    begin
      cold_warm_start_flag   <= next_cold_warm_start_flag;
      protect_bit_zero       <= next_protect_bit_zero;
      protect_bit_one        <= next_protect_bit_one;
      clk_src_sel            <= next_clk_src_sel;
      high_speed_internal_osc_en                <= next_high_speed_internal_osc_en;
      main_osc_en            <= next_main_osc_en;
      pll_en                 <= next_pll_en;
      volt_mon2_control_zero <= next_volt_mon2_control_zero;
      volt_mon2_control_one  <= next_volt_mon2_control_one;
      volt_mon2_status       <= next_volt_mon2_status;
      rtc_control            <= next_rtc_control;
      reset_source           <= next_reset_source;
      sw_reset_req           <= next_sw_reset_req;
      system_reset           <= next_system_reset;
    end
  end

endmodule // rsg_top

// ### rtl/rsg_pkg.sv
/*
  package of the reset scope and write guard block: register offsets,
  field positions, reset values and per-source initialization masks.
  assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
package rsg_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [9:0] OFF_RESET_STATUS_ONE   = 10'h000;
  localparam logic [9:0] OFF_WRITE_PROTECT_CTRL = 10'h004;
  localparam logic [9:0] OFF_SOFT_RESET         = 10'h008;
  localparam logic [9:0] OFF_CLOCK_CONTROL      = 10'h00c;
  localparam logic [9:0] OFF_VOLT_MON2_CTRL0    = 10'h010;
  localparam logic [9:0] OFF_VOLT_MON2_CTRL1    = 10'h014;
  localparam logic [9:0] OFF_VOLT_MON2_STATUS   = 10'h018;
  localparam logic [9:0] OFF_RTC_CONTROL        = 10'h01c;
  localparam logic [9:0] OFF_RESET_SOURCE       = 10'h020;
  localparam logic [9:0] OFF_BACKUP_BASE        = 10'h100;

  // ==========================================================
  // field positions
  localparam int BIT_COLD_WARM     = 0;
  localparam int BIT_PROTECT_ZERO  = 0;
  localparam int BIT_PROTECT_ONE   = 1;
  localparam int BIT_SOFT_RESET    = 0;
  localparam int BIT_HIGH_SPEED_INTERNAL_OSC_EN       = 4;
  localparam int BIT_MAIN_OSC_EN   = 5;
  localparam int BIT_PLL_EN        = 6;
  localparam int BIT_VMON2_DETECT  = 0;

  // clock source select codes
  localparam logic [1:0] CLK_SRC_LOW_SPEED_INTERNAL_OSC = 2'h0;
  localparam logic [1:0] CLK_SRC_HIGH_SPEED_INTERNAL_OSC = 2'h1;
  localparam logic [1:0] CLK_SRC_MAIN = 2'h2;
  localparam logic [1:0] CLK_SRC_PLL  = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_VOLT_MON2     = 8'h00;
  localparam logic [7:0] RST_RTC_LOW       = 8'h0;
  localparam logic [1:0] RST_PROTECT       = 2'h0;

  // ==========================================================
  // reset source bit positions within the request vector
  localparam int SRC_PIN          = 0;
  localparam int SRC_VMON0        = 1;
  localparam int SRC_IWDT         = 2;
  localparam int SRC_WDT          = 3;
  localparam int SRC_VMON1        = 4;
  localparam int SRC_VMON2        = 5;
  localparam int SRC_DEEP_STANDBY = 6;
  localparam int SRC_SOFTWARE     = 7;
  localparam int NUM_SRC          = 8;

  // sources that initialize each register group
  localparam logic [7:0] SCOPE_ALL        = 8'hff;
  localparam logic [7:0] SCOPE_OSC_ENABLE = 8'hbf;
  localparam logic [7:0] SCOPE_VMON2_CTRL0 = 8'h1f;
  localparam logic [7:0] SCOPE_VMON2_CR1_SR = 8'h5f;

  // backup memory geometry
  localparam int BACKUP_DEPTH = 32;
  localparam int BACKUP_WIDTH = 8;

endpackage : rsg_pkg

// ### rtl/rsg_backup_mem.sv
/*
  deep-standby backup memory: a small array with a registered read port.
  assumes one clock; the array has no reset so contents survive every reset.
*/
`timescale 1ns/1ps
module rsg_backup_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic             hclk,
  // read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data
);

  // ==========================================================
  // storage, never initialized
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge hclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // rsg_backup_mem

// ### sim/rsg_top_sva.sv
/*
  checker of the rsg_top ports, bound into every rsg_top.
  assumes one slave on the bus, so hready follows hreadyout.
*/
`timescale 1ns/1ps
module rsg_top_chk
  import rsg_pkg::*;
#(
  parameter int BK_DEPTH = BACKUP_DEPTH,
  parameter int BK_WIDTH = BACKUP_WIDTH
) (
  // clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // bus
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // reset and clock controls
  input wire logic [NUM_SRC-2:0] reset_req,
  input wire logic [1:0]         clk_src_sel,
  input wire logic               high_speed_internal_osc_en,
  input wire logic               main_osc_en,
  input wire logic               pll_en,
  input wire logic               sw_reset_req,
  input wire logic               system_reset
);
  // ==========================================================
  // shadow of the protect bits
  logic       ph_clk, ph_prt, next_ph_clk, next_ph_prt;
  logic [1:0] prot, next_prot;
  wire        taken = hsel && htrans[1] && hready && hreadyout;

  always_comb
  begin
    next_ph_clk = ph_clk;
    next_ph_prt = ph_prt;
    next_prot   = prot;
    if (taken)
    begin
      next_ph_clk = hwrite && (haddr[9:0] == OFF_CLOCK_CONTROL);
      next_ph_prt = hwrite && (haddr[9:0] == OFF_WRITE_PROTECT_CTRL);
    end
    else if (hreadyout)
    begin
      next_ph_clk = 1'b0;
      next_ph_prt = 1'b0;
    end
    if (ph_prt && !hreadyout)
      next_prot = hwdata[1:0];
    if (|reset_req || sw_reset_req)
      next_prot = 2'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_clk <= 1'b0;
      ph_prt <= 1'b0;
      prot   <= 2'h0;
    end
    else
    begin
      ph_clk <= next_ph_clk;
      ph_prt <= next_ph_prt;
      prot   <= next_prot;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("data phase not two cycles");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  sw_pulse_a: assert property (sw_reset_req |=> !sw_reset_req && system_reset)
    else $error("software reset pulse wrong");
  src_reset_a: assert property (|reset_req |=> system_reset)
    else $error("no system reset after source");
  clk_default_a: assert property (system_reset |-> clk_src_sel == CLK_SRC_LOW_SPEED_INTERNAL_OSC && !pll_en)
    else $error("clock source not low speed after reset");
  osc_stop_a: assert property (system_reset && !$past(reset_req[SRC_DEEP_STANDBY])
    |-> !high_speed_internal_osc_en && !main_osc_en)
    else $error("oscillator left running after reset");
  clk_guard_a: assert property ($changed({clk_src_sel, high_speed_internal_osc_en, main_osc_en, pll_en})
    && !system_reset |-> $past(ph_clk) && $past(prot) != 2'h0)
    else $error("clock control changed without permission");
  sw_guard_a: assert property (sw_reset_req |-> $past(prot[BIT_PROTECT_ONE]))
    else $error("software reset without protect bit one");

  cover property (sw_reset_req);
  cover property (system_reset && high_speed_internal_osc_en);
  cover property (taken && !hwrite);
endmodule // rsg_top_chk

bind rsg_top rsg_top_chk #(.BK_DEPTH(BK_DEPTH), .BK_WIDTH(BK_WIDTH)) i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .reset_req, .clk_src_sel, .high_speed_internal_osc_en, .main_osc_en, .pll_en,
  .sw_reset_req, .system_reset
);

// ### sim/rsg_top_test.sv
/*
  self-checking bench of rsg_top over ahb-lite.
  assumes the bench is the only master and the only clock source.
*/
`timescale 1ns/1ps
module rsg_top_test
  import rsg_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, vmon2_detect, hready;
  logic        high_speed_internal_osc_en, main_osc_en, pll_en, sw_reset_req, system_reset;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, clk_src_sel;
  logic [2:0]  hsize;
  logic [6:0]  reset_req;
  int          error_cnt, n_tests;

  assign hready = hreadyout;

  rsg_top i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .reset_req, .vmon2_detect, .clk_src_sel,
    .high_speed_internal_osc_en, .main_osc_en, .pll_en, .sw_reset_req, .system_reset
  );

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    // address phase held until hready is sampled high at a rising edge
    do
    begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // data phase held until hready is sampled high again; data taken there
    do
    begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rc(input logic [9:0] a, input logic [31:0] exp, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #40000;
    error_cnt++;
    summarize();
  end

  // ==========================================================
  // tests
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    reset_req = 7'h0;
    vmon2_detect = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(OFF_RESET_STATUS_ONE, 32'h0, "cold flag");
    rc(OFF_CLOCK_CONTROL, 32'h0, "clock control");
    rc(10'h040, 32'h0, "unmapped");
    wr(OFF_CLOCK_CONTROL, 32'h73);
    rc(OFF_CLOCK_CONTROL, 32'h0, "unprotected write");
    wr(OFF_WRITE_PROTECT_CTRL, 32'h2);
    wr(OFF_CLOCK_CONTROL, 32'h72);
    rc(OFF_CLOCK_CONTROL, 32'h72, "protect one write");
    chk("pll_en", {31'h0, pll_en}, 32'h1);
    wr(OFF_RESET_STATUS_ONE, 32'h1);
    wr(OFF_RESET_STATUS_ONE, 32'h0);
    rc(OFF_RESET_STATUS_ONE, 32'h1, "warm flag");
    wr(OFF_BACKUP_BASE, 32'ha5);
    wr(OFF_BACKUP_BASE + 10'h07c, 32'h3c);
    // every source in turn, software reset last
    for (int s = 0; s < 8; s++)
    begin
      wr(OFF_WRITE_PROTECT_CTRL, 32'h1);
      wr(OFF_CLOCK_CONTROL, 32'h73);
      wr(OFF_RTC_CONTROL, 32'hff);
      wr(OFF_VOLT_MON2_CTRL0, 32'h5);
      wr(OFF_VOLT_MON2_CTRL1, 32'h6);
      vmon2_detect <= 1'b1;
      @(posedge hclk);
      vmon2_detect <= 1'b0;
      if (s < 7)
      begin
        reset_req <= 7'h1 << s;
        @(posedge hclk);
        reset_req <= 7'h0;
      end
      else
      begin
        wr(OFF_SOFT_RESET, 32'h1);
        rc(OFF_CLOCK_CONTROL, 32'h73, "blocked soft reset");
        wr(OFF_WRITE_PROTECT_CTRL, 32'h2);
        wr(OFF_SOFT_RESET, 32'h1);
      end
      @(posedge hclk);
      chk("system_reset", {31'h0, system_reset}, 32'h1);
      @(posedge hclk);
      rc(OFF_CLOCK_CONTROL, (s == 6) ? 32'h30 : 32'h0, "clock after reset");
      chk("osc outputs", {27'h0, pll_en, main_osc_en, high_speed_internal_osc_en, clk_src_sel},
          (s == 6) ? 32'hc : 32'h0);
      rc(OFF_WRITE_PROTECT_CTRL, 32'h0, "protect after reset");
      rc(OFF_RTC_CONTROL, 32'hf0, "rtc control");
      rc(OFF_VOLT_MON2_CTRL0, (s < 5) ? 32'h0 : 32'h5, "vmon2 ctrl0");
      rc(OFF_VOLT_MON2_CTRL1, (s < 5 || s == 6) ? 32'h0 : 32'h6, "vmon2 ctrl1");
      rc(OFF_VOLT_MON2_STATUS, (s < 5 || s == 6) ? 32'h0 : 32'h1, "vmon2 status");
      rc(OFF_RESET_SOURCE, 32'h1 << s, "reset source");
      rc(OFF_RESET_STATUS_ONE, 32'h1, "flag kept");
      rc(OFF_BACKUP_BASE + 10'h07c, 32'h3c, "backup kept");
    end
    // power-on reset in mid-run
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(OFF_RESET_STATUS_ONE, 32'h0, "cold flag again");
    rc(OFF_BACKUP_BASE, 32'ha5, "backup after power-on");
    summarize();
  end
endmodule // rsg_top_test
